// ### rtl/gwpm_pkg.sv
// Package for the GPIO wake and power mode block: widths, timing, types.
// Assumes a single 20 MHz system clock domain.
package gwpm_pkg;
  localparam int unsigned PA_W = 8;
  localparam int unsigned PB_W = 5;
  localparam int unsigned PC_W = 6;
  localparam int unsigned PIN_W = 19;
  localparam int unsigned PB_LSB = 8;
  localparam int unsigned PC_LSB = 13;
  // Alternate function presence per pin, port B is analog only
  localparam logic [18:0] AF_PRESENT = 19'h7e0ff;
  // I2C clock and data on port A bits 6 and 7
  localparam logic [18:0] AF_OPEN_DRAIN = 19'h000c0;
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned GLITCH_NS = 10;
  // Least time, rounded up, never below one cycle
  localparam int unsigned GLITCH_CYC_RAW =
    (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GLITCH_CYC =
    (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
  localparam int unsigned WDO_CYC = 66;
  localparam int unsigned SYS_CYC = 16;
  localparam int unsigned CNT_W = 8;
  localparam logic [7:0] WDO_CNT = 8'h42;
  localparam logic [7:0] SYS_CNT = 8'h10;

  typedef enum logic [4:0] {
    GWPM_RUN = 5'h01,
    GWPM_HALT = 5'h02,
    GWPM_STOP = 5'h04,
    GWPM_RECW = 5'h08,
    GWPM_RECS = 5'h10
  } gwpm_state_t;

  // Peripheral side of each pin when handed over
  typedef struct packed {
    logic [18:0] out;
    logic [18:0] oe;
  } gwpm_af_t;

  // Pin configuration
  typedef struct packed {
    logic [18:0] dirIn;
    logic [18:0] altSel;
    logic [18:0] openDrain;
    logic [18:0] wakeEn;
    logic [18:0] outVal;
  } gwpm_cfg_t;

  // Power gating outputs
  typedef struct packed {
    logic cpuRun;
    logic sysClkEn;
    logic xtalEn;
    logic wdtRun;
    logic bodOn;
    logic periphRun;
    logic inReset;
  } gwpm_pwr_t;
endpackage

// ### rtl/gwpm_pin_mux.sv
// Pin multiplexer: port direction or alternate function drives each pin.
// Assumes pins are sampled elsewhere; no inout, three signals per pin.
`timescale 1ns/1ps
module gwpm_pin_mux
(
  // Configuration and peripheral
  input wire gwpm_pkg::gwpm_cfg_t cfg,
  input wire gwpm_pkg::gwpm_af_t af,
  // Pin driver
  output logic [18:0] pinOut,
  output logic [18:0] pinOe
);
  import gwpm_pkg::*;

  wire [18:0] useAf;
  wire [18:0] rawOut;
  wire [18:0] rawOe;
  wire [18:0] odMode;

  assign useAf = cfg.altSel & AF_PRESENT;
  assign rawOe = (useAf & af.oe) | (~useAf & ~cfg.dirIn);
  assign rawOut = (useAf & af.out) | (~useAf & cfg.outVal);
  assign odMode = cfg.openDrain | (useAf & AF_OPEN_DRAIN);
  // Open drain only ever pulls low
  assign pinOe = rawOe & ~(odMode & rawOut);
  assign pinOut = rawOut & ~odMode;
endmodule // gwpm_pin_mux

// ### rtl/gwpm_wake_det.sv
// Wake detector: compares enabled pins against the level latched at STOP.
// Assumes latch is stable while system clock is gated.
`timescale 1ns/1ps
module gwpm_wake_det
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Control
  input wire logic latchNow,
  input wire logic [18:0] pinIn,
  input wire logic [18:0] wakeEn,
  // Result
  output logic wakeReq
);
  import gwpm_pkg::*;

  logic [18:0] ref_ff;
  logic [7:0] stable_ff;
  wire [18:0] diff;
  wire anyDiff;

  assign diff = (pinIn ^ ref_ff) & wakeEn;
  assign anyDiff = |diff;

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      ref_ff <= 19'h00000;
    else if (latchNow)
      ref_ff <= pinIn;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst || latchNow || !anyDiff)
      stable_ff <= 8'h00;
    else if (stable_ff < 8'(GLITCH_CYC))
      stable_ff <= stable_ff + 8'h01;
  end

  assign wakeReq = anyDiff && (stable_ff >= 8'(GLITCH_CYC - 1));
endmodule // gwpm_wake_det

// ### rtl/gwpm_top.sv
// Top of GPIO wake and power mode block: mode machine, recovery timing,
// input capture and pin muxing. Assumes wdtOscTick pulses once per
// watchdog oscillator cycle, synchronous to sys_clk; sys_clk keeps a
// free-running model clock while STOP gates the device clock outward.
`timescale 1ns/1ps
module gwpm_top
#(
  parameter int unsigned WDO_CYCLES = 66,
  parameter int unsigned SYS_CYCLES = 16
)
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // CPU instructions and wake events
  input wire logic stopInstr,
  input wire logic haltInstr,
  input wire logic irqPending,
  input wire logic wdtTimeout,
  input wire logic porEvent,
  input wire logic bodEvent,
  input wire logic extResetEvent,
  input wire logic wdtOscTick,
  // Options
  input wire logic wdtStopEn,
  input wire logic wdtEnable,
  input wire logic bodStopEn,
  input wire logic stopFlagClr,
  // Pin configuration
  input wire gwpm_pkg::gwpm_cfg_t cfg,
  // Pin pads
  input wire logic [18:0] pinIn,
  output logic [18:0] pinOut,
  output logic [18:0] pinOe,
  output logic crystalInPin,
  output logic crystalOutPin,
  // Port A alternate functions
  output logic timer0_input,
  input wire logic timer0_output,
  input wire logic uart_driver_enable,
  output logic uart_clear_to_send,
  output logic uart_receive,
  input wire logic uart_transmit,
  output logic i2cSclIn,
  input wire logic i2cSclLow,
  output logic i2cSdaIn,
  input wire logic i2cSdaLow,
  // Port C alternate functions
  output logic timer1_input,
  input wire logic timer1_output,
  output logic spiSsIn,
  output logic spiSckIn,
  input wire logic spiSckOut,
  input wire logic spiSckOe,
  output logic spiMosiIn,
  input wire logic spiMosiOut,
  input wire logic spiMosiOe,
  output logic spiMisoIn,
  input wire logic spiMisoOut,
  input wire logic spiMisoOe,
  // Status
  output logic [18:0] port_input_value_reg,
  output logic [18:0] pinEdgeIrq,
  output logic stopRecoveryFlag,
  output gwpm_pkg::gwpm_pwr_t pwr,
  output gwpm_pkg::gwpm_state_t mode
);
  import gwpm_pkg::*;

  gwpm_state_t state_ff;
  gwpm_state_t nxt_state;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [18:0] inReg_ff;
  logic [18:0] irq_ff;
  logic stopFlag_ff;
  gwpm_af_t af;
  wire wakeReq;
  wire haltExit;
  wire enterStop;
  wire enterHalt;
  wire wdoDone;
  wire sysDone;
  wire inStop;
  wire inRun;

  localparam logic [7:0] WDO_LAST = 8'(WDO_CYCLES - 1);
  localparam logic [7:0] SYS_LAST = 8'(SYS_CYCLES - 1);
  localparam logic [7:0] WDO_LEN = 8'(WDO_CYCLES);
  localparam logic [7:0] SYS_LEN = 8'(SYS_CYCLES);

  assign inStop = (state_ff == GWPM_STOP);
  assign inRun = (state_ff == GWPM_RUN);
  assign enterStop = inRun && stopInstr;
  assign enterHalt = inRun && haltInstr && !stopInstr;
  assign haltExit = irqPending || wdtTimeout || porEvent || bodEvent ||
    extResetEvent;
  assign wdoDone = wdtOscTick && (cnt_ff == WDO_LAST);
  assign sysDone = (cnt_ff == SYS_LAST);

  gwpm_wake_det u_wake
  (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .latchNow(enterStop),
    .pinIn(pinIn),
    .wakeEn(cfg.wakeEn & {19{inStop}}),
    .wakeReq(wakeReq)
  );

  // Mode machine
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      GWPM_RUN:
      begin
        if (enterStop)
          nxt_state = GWPM_STOP;
        else if (enterHalt)
          nxt_state = GWPM_HALT;
        nxt_cnt = 8'h00;
      end
      GWPM_HALT:
      begin
        if (haltExit)
          nxt_state = GWPM_RUN;
      end
      GWPM_STOP:
      begin
        if (wakeReq || (wdtTimeout && wdtStopEn && wdtEnable))
          nxt_state = GWPM_RECW;
        nxt_cnt = 8'h00;
      end
      GWPM_RECW:
      begin
        if (wdoDone)
        begin
          nxt_state = GWPM_RECS;
          nxt_cnt = 8'h00;
        end
        else if (wdtOscTick)
          nxt_cnt = cnt_ff + 8'h01;
      end
      GWPM_RECS:
      begin
        if (sysDone)
        begin
          nxt_state = GWPM_RUN;
          nxt_cnt = 8'h00;
        end
        else
          nxt_cnt = cnt_ff + 8'h01;
      end
      default:
      begin
        nxt_state = GWPM_RUN;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state_ff <= GWPM_RUN;
      cnt_ff <= 8'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      stopFlag_ff <= 1'b0;
    end
    else
    begin
      // Set wins over a clear in the same cycle
      if (inStop && wakeReq)
        stopFlag_ff <= 1'b1;
      else if (stopFlagClr)
        stopFlag_ff <= 1'b0;
    end
  end

  // input register only samples in run or halt
  // short pulses gone before recovery ends
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      inReg_ff <= 19'h00000;
      irq_ff <= 19'h00000;
    end
    else if (inRun || state_ff == GWPM_HALT)
    begin
      inReg_ff <= pinIn;
      irq_ff <= pinIn ^ inReg_ff;
    end
    else
      irq_ff <= 19'h00000;
  end

  assign port_input_value_reg = inReg_ff;
  assign pinEdgeIrq = irq_ff;
  assign stopRecoveryFlag = stopFlag_ff;
  assign mode = state_ff;

  assign crystalInPin = inStop;
  assign crystalOutPin = 1'b0;

  assign pwr.xtalEn = !inStop;
  assign pwr.sysClkEn = !inStop;
  assign pwr.cpuRun = inRun;
  assign pwr.periphRun = inRun || (state_ff == GWPM_HALT);
  assign pwr.wdtRun = inStop ? (wdtEnable && wdtStopEn) : wdtEnable;
  assign pwr.bodOn = inStop ? bodStopEn : 1'b1;
  assign pwr.inReset = (state_ff == GWPM_RECW) ||
    (state_ff == GWPM_RECS);

  assign af.out[7:0] = {1'b0, 1'b0, uart_transmit, 1'b0, 1'b0,
    uart_driver_enable, timer0_output, 1'b0};
  assign af.oe[7:0] = {i2cSdaLow, i2cSclLow, 1'b1, 1'b0, 1'b0, 1'b1,
    1'b1, 1'b0};
  assign af.out[12:8] = 5'h00;
  assign af.oe[12:8] = 5'h00;
  assign af.out[18:13] = {spiMisoOut, spiMosiOut, spiSckOut, 1'b0,
    timer1_output, 1'b0};
  assign af.oe[18:13] = {spiMisoOe, spiMosiOe, spiSckOe, 1'b0, 1'b1,
    1'b0};
  assign timer0_input = pinIn[0];
  assign uart_clear_to_send = pinIn[3];
  assign uart_receive = pinIn[4];
  assign i2cSclIn = pinIn[6];
  assign i2cSdaIn = pinIn[7];
  assign timer1_input = pinIn[PC_LSB];
  assign spiSsIn = pinIn[PC_LSB + 2];
  assign spiSckIn = pinIn[PC_LSB + 3];
  assign spiMosiIn = pinIn[PC_LSB + 4];
  assign spiMisoIn = pinIn[PC_LSB + 5];

  gwpm_pin_mux u_mux
  (
    .cfg(cfg),
    .af(af),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  // Recovery steps as sequences
  sequence s_stopWake;
    inStop && wakeReq;
  endsequence
  sequence s_recov;
    state_ff == GWPM_RECW;
  endsequence

  // Independent tallies of both recovery phases
  logic [7:0] recwTicks_ff;
  logic [7:0] recsLen_ff;
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || state_ff != GWPM_RECW)
      recwTicks_ff <= 8'h00;
    else if (wdtOscTick)
      recwTicks_ff <= recwTicks_ff + 8'h01;
  end
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || state_ff != GWPM_RECS)
      recsLen_ff <= 8'h00;
    else
      recsLen_ff <= recsLen_ff + 8'h01;
  end

  a_wake_recovery: assert property (
    @(posedge sys_clk) disable iff (!nrst) s_stopWake |=> s_recov)
    else $error("pin wake did not start recovery");
  a_stop_flag: assert property (
    @(posedge sys_clk) disable iff (!nrst) s_stopWake |=> stopRecoveryFlag)
    else $error("stop flag not set");
  a_input_frozen: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    inStop |=> $stable(port_input_value_reg))
    else $error("input register changed in stop");
  a_crystal_pins: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    inStop |-> crystalInPin && !crystalOutPin && !pwr.xtalEn)
    else $error("crystal pins wrong in stop");
  a_stop_gating: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    inStop |-> !pwr.sysClkEn && !pwr.cpuRun && !pwr.periphRun)
    else $error("stop gating wrong");
  a_wdt_stop: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    inStop && !wdtStopEn |-> !pwr.wdtRun)
    else $error("watchdog running in stop");
  a_bod_stop: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    inStop |-> pwr.bodOn == bodStopEn)
    else $error("brownout enable wrong in stop");
  a_halt_exit: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_ff == GWPM_HALT && haltExit |=> inRun)
    else $error("halt not left on event");
  a_halt_clocks: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_ff == GWPM_HALT |-> pwr.sysClkEn && !pwr.cpuRun)
    else $error("halt clocking wrong");
  a_halt_periph: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    state_ff == GWPM_HALT |-> pwr.periphRun && pwr.wdtRun == wdtEnable)
    else $error("peripherals stopped in halt");
  a_wdo_phase: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(state_ff == GWPM_RECW) |->
    state_ff == GWPM_RECS && recwTicks_ff == WDO_LEN)
    else $error("watchdog recovery phase length wrong");
  a_sys_phase: assert property (
    @(posedge sys_clk) disable iff (!nrst)
    $fell(state_ff == GWPM_RECS) |-> inRun && recsLen_ff == SYS_LEN)
    else $error("system clock recovery phase length wrong");
endmodule // gwpm_top

// ### sim/gwpm_pad_model.sv
// Far-side model: pin pads and the slow watchdog RC oscillator tick.
// Assumes one bench clock; undriven pads show the far-side level.
`timescale 1ns/1ps
module gwpm_pad_model
(
  // Clock
  input wire logic sys_clk,
  // Device drive and far-side level
  input wire logic [18:0] pinOut,
  input wire logic [18:0] pinOe,
  input wire logic [18:0] extLevel,
  // To the device
  output logic [18:0] pinIn,
  output logic wdtOscTick
);
  logic [1:0] divCnt = 2'h0;
  logic tickNow;
  initial wdtOscTick = 1'b0;
  // Driven pad follows the device, else the far side
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
  assign tickNow = (divCnt == 2'h2);
  // RC tick every third clock, far slower than the crystal
  always @(posedge sys_clk)
  begin
    divCnt <= tickNow ? 2'h0 : divCnt + 2'h1;
    wdtOscTick <= tickNow;
  end
endmodule // gwpm_pad_model

// ### sim/test_gwpm_top.sv
// Self-checking bench for the GPIO wake and power mode block.
// Assumes the pad model closes the pin loop and ticks the RC clock.
`timescale 1ns/1ps
module test_gwpm_top;
  import gwpm_pkg::*;
  typedef struct packed {logic [3:0] sel; logic [31:0] val;} gwpm_note_t;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic stopInstr = 1'b0;
  logic haltInstr = 1'b0;
  logic [4:0] haltSrc = 5'h00;
  logic wdtStopEn = 1'b0;
  logic wdtEnable = 1'b1;
  logic bodStopEn = 1'b1;
  logic stopFlagClr = 1'b0;
  logic [11:0] afIn = 12'h000;
  logic [18:0] extLevel = 19'h00000;
  gwpm_cfg_t cfg = '0;
  logic [18:0] pinIn, pinOut, pinOe, portReg, edgeIrq;
  logic [18:0] outR, extR, oeE, outE, padE;
  logic [18:0] irqSeen = 19'h00000;
  logic [9:0] afSeen;
  logic crystal_in_pin, crystal_out_pin, flag, tick;
  gwpm_pwr_t pwr;
  gwpm_state_t mode;
  gwpm_note_t notes[$];
  gwpm_note_t curNote;
  int bad_count = 0;
  int num_checks = 0;
  int cntW = 0;
  int cntS = 0;

  gwpm_top #(.WDO_CYCLES(66), .SYS_CYCLES(16)) u_gwpm_top (
    .sys_clk(sys_clk), .nrst(nrst), .stopInstr(stopInstr),
    .haltInstr(haltInstr), .irqPending(haltSrc[0]),
    .wdtTimeout(haltSrc[1]), .porEvent(haltSrc[2]),
    .bodEvent(haltSrc[3]), .extResetEvent(haltSrc[4]),
    .wdtOscTick(tick), .wdtStopEn(wdtStopEn), .wdtEnable(wdtEnable),
    .bodStopEn(bodStopEn), .stopFlagClr(stopFlagClr), .cfg(cfg),
    .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .crystalInPin(crystal_in_pin), .crystalOutPin(crystal_out_pin),
    .timer0_input(afSeen[9]), .timer0_output(afIn[0]),
    .uart_driver_enable(afIn[1]), .uart_clear_to_send(afSeen[8]),
    .uart_receive(afSeen[7]), .uart_transmit(afIn[2]),
    .i2cSclIn(afSeen[6]), .i2cSclLow(afIn[3]),
    .i2cSdaIn(afSeen[5]), .i2cSdaLow(afIn[4]),
    .timer1_input(afSeen[4]), .timer1_output(afIn[5]),
    .spiSsIn(afSeen[3]), .spiSckIn(afSeen[2]), .spiSckOut(afIn[6]),
    .spiSckOe(afIn[7]), .spiMosiIn(afSeen[1]), .spiMosiOut(afIn[8]),
    .spiMosiOe(afIn[9]), .spiMisoIn(afSeen[0]), .spiMisoOut(afIn[10]),
    .spiMisoOe(afIn[11]), .port_input_value_reg(portReg),
    .pinEdgeIrq(edgeIrq), .stopRecoveryFlag(flag), .pwr(pwr),
    .mode(mode));

  gwpm_pad_model u_gwpm_pad_model (
    .sys_clk(sys_clk), .pinOut(pinOut), .pinOe(pinOe),
    .extLevel(extLevel), .pinIn(pinIn), .wdtOscTick(tick));

  always #25 sys_clk = ~sys_clk;

  function automatic logic [31:0] observe(input logic [3:0] sel);
    case (sel)
      4'h0: return {27'h0, mode};
      4'h1: return {31'h0, flag};
      4'h2: return {13'h0, portReg};
      4'h3: return {13'h0, pinOut & pinOe};
      4'h4: return {13'h0, pinOe};
      4'h5: return {30'h0, crystal_in_pin, crystal_out_pin};
      4'h6: return {25'h0, pwr};
      4'h7: return 32'(cntW);
      4'h8: return 32'(cntS);
      4'h9: return {13'h0, irqSeen};
      default: return {22'h0, afSeen};
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic expect_val(input logic [3:0] sel, input logic [31:0] val);
    notes.push_back('{sel, val});
  endtask

  task automatic expect_mode(input gwpm_state_t m);
    expect_val(4'h0, {27'h0, m});
  endtask

  // Watcher: tallies recovery phases, then settles every open note
  always @(negedge sys_clk)
  begin
    if (mode === GWPM_RECW && tick === 1'b1)
      cntW++;
    if (mode === GWPM_RECS)
      cntS++;
    irqSeen = irqSeen | edgeIrq;
    while (notes.size() > 0)
    begin
      curNote = notes.pop_front();
      check(observe(curNote.sel), curNote.val);
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic enter_stop;
    stopInstr = 1'b1;
    step(1);
    stopInstr = 1'b0;
    irqSeen = 19'h00000;
    cntW = 0;
    cntS = 0;
  endtask

  // Bounded wait; running out counts as a mismatch
  task automatic wait_run;
    int k;
    k = 0;
    while (k < 400 && mode !== GWPM_RUN)
    begin
      step(1);
      k++;
    end
    if (k == 400)
      bad_count++;
    step(3);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end

  initial
  begin
    void'($urandom(32'hcf56b7df));
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'b1;
    expect_mode(GWPM_RUN);
    expect_val(4'h1, 32'h0);
    expect_val(4'h2, 32'h0);
    repeat (4)
    begin
      outR = 19'($urandom);
      extR = 19'($urandom);
      afIn = 12'($urandom);
      cfg = '0;
      cfg.outVal = outR;
      extLevel = extR;
      step(1);
      expect_val(4'h4, 32'h7ffff);
      expect_val(4'h3, {13'h0, outR});
      step(1);
      cfg.dirIn = 19'h7ffff;
      step(3);
      expect_val(4'h4, 32'h0);
      expect_val(4'h2, {13'h0, extR});
      step(1);
      // Port B has no function, so its select must be ignored
      cfg.altSel = 19'h7ffff;
      cfg.dirIn = 19'h7e0ff;
      step(1);
      oeE = {afIn[11], afIn[9], afIn[7], 3'h2, 5'h1f, afIn[4], afIn[3],
             6'h26};
      outE = {afIn[10], afIn[8], afIn[6], 1'b0, afIn[5], 1'b0,
              outR[12:8], 2'h0, afIn[2], 2'h0, afIn[1], afIn[0], 1'b0};
      padE = (oeE & outE) | (~oeE & extR);
      expect_val(4'h4, {13'h0, oeE});
      expect_val(4'h3, {13'h0, outE & oeE});
      expect_val(4'ha, {22'h0, padE[0], padE[3], padE[4], padE[6],
                 padE[7], padE[13], padE[15], padE[16], padE[17],
                 padE[18]});
      step(1);
    end
    afIn = 12'h000;
    expect_val(4'h6, 32'h7e);
    for (int i = 0; i < 5; i++)
    begin
      haltInstr = 1'b1;
      step(1);
      haltInstr = 1'b0;
      expect_mode(GWPM_HALT);
      expect_val(4'h6, 32'h3e);
      step(2);
      expect_mode(GWPM_HALT);
      haltSrc = 5'h01 << i;
      step(1);
      haltSrc = 5'h00;
      expect_mode(GWPM_RUN);
    end
    cfg = '0;
    cfg.dirIn = 19'h7ffff;
    cfg.wakeEn = 19'h00008;
    extLevel = 19'h00000;
    step(3);
    enter_stop();
    expect_mode(GWPM_STOP);
    expect_val(4'h5, 32'h2);
    expect_val(4'h6, 32'h04);
    extLevel[5] = 1'b1;
    step(3);
    expect_mode(GWPM_STOP);
    expect_val(4'h2, 32'h0);
    extLevel[3] = 1'b1;
    step(1);
    expect_mode(GWPM_RECW);
    expect_val(4'h6, 32'h3d);
    step(1);
    expect_val(4'h1, 32'h1);
    wait_run();
    expect_val(4'h7, 32'(WDO_CYC));
    expect_val(4'h8, 32'(SYS_CYC));
    expect_val(4'h2, 32'h28);
    expect_val(4'h9, 32'h28);
    stopFlagClr = 1'b1;
    step(1);
    stopFlagClr = 1'b0;
    expect_val(4'h1, 32'h0);
    wdtStopEn = 1'b1;
    bodStopEn = 1'b0;
    enter_stop();
    expect_val(4'h6, 32'h08);
    step(2);
    extLevel[3] = 1'b0;
    step(1);
    extLevel[3] = 1'b1;
    expect_mode(GWPM_RECW);
    wait_run();
    expect_val(4'h2, 32'h28);
    expect_val(4'h9, 32'h0);
    expect_val(4'h1, 32'h1);
    step(2);
    // Watchdog timeout wakes only when enabled for STOP
    wdtStopEn = 1'b0;
    enter_stop();
    haltSrc = 5'h02;
    step(1);
    expect_mode(GWPM_STOP);
    wdtStopEn = 1'b1;
    step(1);
    haltSrc = 5'h00;
    expect_mode(GWPM_RECW);
    wait_run();
    expect_val(4'h7, 32'(WDO_CYC));
    expect_val(4'h8, 32'(SYS_CYC));
    expect_mode(GWPM_RUN);
    step(2);
    finish_test();
  end
endmodule // test_gwpm_top
